// ==== rtl/mfd_decoder.sv ====
// Instruction field decoder with literal subtract, APB slave
module mfd_decoder
  import mfd_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Decoded fields, accumulator and status flags
  output logic             dest_to_file,
  output logic [3:0]       bank_sel,
  output logic [11:0]      file_addr,
  output logic [11:0]      move_dest,
  output logic [2:0]       bit_pos,
  output logic [7:0]       literal,
  output logic [19:0]      jump_target,
  output logic             pair_done,
  output logic [7:0]       working_accumulator,
  output logic [4:0]       status_flags
);
`include "mfd_map.svh"
  // Only the 12-bit offset space is decoded; other widths are refused at elaboration
  if (ADDR_W != 12) begin : g_addr_w_check
    $error("mfd_decoder: ADDR_W must be 12");
  end

  // Local state
  logic [15:0]  instr_r;
  logic         instr_new_r;
  logic         sub_pend_r;
  logic         sub_rdy_r;
  logic [3:0]   bank_select_register;
  logic [7:0]   first_low_r;
  logic [11:0]  first_src_r;
  mfd_wait_e    wait_r;
  logic [26:0]  count_r;
  logic [7:0]   diff;
  logic [4:0]   flags_nxt;
  logic [7:0]   sub_lit_r;
  mfd_qphase_e  q;
  logic         wr_en;
  logic         acc_wr;
  logic         ctrl_wr;
  logic         prefixed;
  logic         is_sublit;

  // Single-cycle APB answer: pready rises in the access phase
  assign wr_en     = psel && penable && pready && pwrite;
  assign acc_wr    = wr_en && (paddr == `MFD_ACC_OFF);
  assign ctrl_wr   = wr_en && (paddr == `MFD_CTRL_OFF);
  assign prefixed  = (instr_r[15:12] == `MFD_PREFIX);
  assign is_sublit = (instr_r[15:8] == `MFD_SUBLIT_OP);

  mfd_qseq u_qseq (
    .pclk    (pclk),
    .presetn (presetn),
    .q       (q)
  );

  mfd_sub_alu u_alu (
    .lit   (sub_lit_r),
    .acc   (working_accumulator),
    .diff  (diff),
    .flags (flags_nxt)
  );

  // APB ready: one wait-free cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Unmapped offsets answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable &&
                 !(paddr inside {`MFD_CTRL_OFF, `MFD_INSTR_OFF, `MFD_ACC_OFF,
                                 `MFD_BANK_OFF, `MFD_FIELDS_OFF, `MFD_ADDR_OFF,
                                 `MFD_STATUS_OFF});
    end
  end

  // Instruction word arrives through the instruction register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_r     <= 16'h0000;
      instr_new_r <= 1'b0;
    end else begin
      instr_new_r <= wr_en && (paddr == `MFD_INSTR_OFF);
      if (wr_en && paddr == `MFD_INSTR_OFF) begin
        instr_r <= pwdata[15:0];
      end
    end
  end

  // Bank select register written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_register <= `MFD_BANK_RST;
    end else if (wr_en && paddr == `MFD_BANK_OFF) begin
      bank_select_register <= pwdata[3:0];
    end
  end

  // Field extraction for each new word taken while no pairing is pending (wait_r == MFD_W_NONE)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_to_file <= 1'b0;
      bank_sel     <= 4'h0;
      file_addr    <= 12'h000;
      bit_pos      <= 3'h0;
      literal      <= 8'h00;
    end else if (instr_new_r && wait_r == MFD_W_NONE) begin
      dest_to_file <= instr_r[`MFD_DEST_BIT];
      bank_sel     <= instr_r[`MFD_ACCESS_BIT] ? bank_select_register : 4'h0;
      file_addr    <= {4'h0, instr_r[7:0]};
      bit_pos      <= instr_r[`MFD_BITPOS_HI:`MFD_BITPOS_LO];
      literal      <= instr_r[7:0];
    end
  end

  // Two-word pairing: ctrl register selects which kind the next word completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r      <= MFD_W_NONE;
      first_low_r <= 8'h00;
      first_src_r <= 12'h000;
      move_dest   <= 12'h000;
      jump_target <= 20'h00000;
      pair_done   <= 1'b0;
    end else begin
      pair_done <= 1'b0;
      if (wr_en && paddr == `MFD_CTRL_OFF) begin
        wait_r      <= mfd_wait_e'(pwdata[1:0]);
      end else if (instr_new_r) begin
        unique case (wait_r)
          MFD_W_NONE: begin
            first_low_r <= instr_r[7:0];
            first_src_r <= instr_r[11:0];
          end
          MFD_W_MOVE: begin
            if (prefixed) begin
              move_dest <= instr_r[11:0];
              pair_done <= 1'b1;
            end
            wait_r <= MFD_W_NONE;
          end
          MFD_W_TARGET: begin
            if (prefixed) begin
              jump_target <= {instr_r[11:0], first_low_r};
              pair_done   <= 1'b1;
            end
            wait_r <= MFD_W_NONE;
          end
          default: wait_r <= MFD_W_NONE;
        endcase
      end
    end
  end

  // Decode in any Q phase marks the word, the next Q2 reads the literal
  // A word decoded late in a cycle waits for the next Q2, so Q4 never uses a stale literal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_pend_r <= 1'b0;
      sub_rdy_r  <= 1'b0;
      sub_lit_r  <= 8'h00;
    end else begin
      // A newer word replaces a decode still waiting for its Q2
      if (instr_new_r) begin
        sub_pend_r <= (wait_r == MFD_W_NONE) && is_sublit;
      end else if (q == MFD_Q2) begin
        sub_pend_r <= 1'b0;
      end
      // Q3 works on the latched literal, Q4 then writes
      if (q == MFD_Q2 && sub_pend_r && !instr_new_r) begin
        sub_lit_r <= instr_r[7:0];
        sub_rdy_r <= 1'b1;
      end else if (q == MFD_Q4) begin
        sub_rdy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_accumulator <= `MFD_ACC_RST;
      status_flags        <= `MFD_FLAGS_RST;
    end else if (wr_en && paddr == `MFD_ACC_OFF) begin
      working_accumulator <= pwdata[7:0];
    end else if (q == MFD_Q4 && sub_rdy_r) begin
      working_accumulator <= diff;
      status_flags        <= flags_nxt;
    end
  end

  // Count for status of subtracts reaching their Q4 write, also one whose result a same-cycle accumulator write overrides
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 27'h000_0000;
    end else if (q == MFD_Q4 && sub_rdy_r) begin
      count_r <= count_r + 27'h000_0001;
    end
  end

  // Read mux, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `MFD_CTRL_OFF:   prdata <= {30'h0, wait_r};
        `MFD_INSTR_OFF:  prdata <= {16'h0, instr_r};
        `MFD_ACC_OFF:    prdata <= {24'h0, working_accumulator};
        `MFD_BANK_OFF:   prdata <= {28'h0, bank_select_register};
        `MFD_FIELDS_OFF: prdata <= {15'h0, sub_pend_r || sub_rdy_r, dest_to_file, bank_sel,
                                    bit_pos, literal};
        `MFD_ADDR_OFF:   prdata <= {8'h0, move_dest, first_src_r};
        `MFD_STATUS_OFF: prdata <= {count_r, status_flags};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions
  // Steps of one literal subtract, and a single word taken for decode
  sequence s_lit_read;
    q == MFD_Q2 && sub_pend_r && !instr_new_r;
  endsequence
  sequence s_acc_write;
    q == MFD_Q4 && sub_rdy_r;
  endsequence
  sequence s_single_word;
    instr_new_r && wait_r == MFD_W_NONE;
  endsequence
  property p_sub_result;
    @(posedge pclk) disable iff (!presetn)
      (q == MFD_Q4 && sub_rdy_r && !acc_wr)
      |=> working_accumulator == ($past(sub_lit_r) - $past(working_accumulator));
  endproperty
  a_sub_result: assert property (p_sub_result) else $error("acc not written");
  property p_carry;
    @(posedge pclk) disable iff (!presetn)
      (q == MFD_Q4 && sub_rdy_r && !acc_wr)
      |=> status_flags[`MFD_FLAG_C] == ($past(sub_lit_r) >= $past(working_accumulator));
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_sub_phases;
    @(posedge pclk) disable iff (!presetn)
      s_lit_read |=> (q == MFD_Q3 && sub_rdy_r) ##1 s_acc_write;
  endproperty
  a_sub_phases: assert property (p_sub_phases) else $error("subtract phases out of order");
  property p_sub_decode;
    @(posedge pclk) disable iff (!presetn)
      (instr_new_r && wait_r == MFD_W_NONE && is_sublit) |=> sub_pend_r;
  endproperty
  a_sub_decode: assert property (p_sub_decode) else $error("subtract not decoded");
  property p_dest;
    @(posedge pclk) disable iff (!presetn)
      s_single_word |=> dest_to_file == $past(instr_r[`MFD_DEST_BIT]);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");
  property p_bank;
    @(posedge pclk) disable iff (!presetn)
      s_single_word |=>
        bank_sel == ($past(instr_r[`MFD_ACCESS_BIT]) ? $past(bank_select_register) : 4'h0);
  endproperty
  a_bank: assert property (p_bank) else $error("bank choice wrong");
  property p_file;
    @(posedge pclk) disable iff (!presetn)
      s_single_word |=> file_addr == {4'h0, $past(instr_r[7:0])};
  endproperty
  a_file: assert property (p_file) else $error("file address wrong");
  property p_bitpos;
    @(posedge pclk) disable iff (!presetn)
      s_single_word |=> bit_pos == $past(instr_r[`MFD_BITPOS_HI:`MFD_BITPOS_LO]);
  endproperty
  a_bitpos: assert property (p_bitpos) else $error("bit position wrong");
  property p_literal;
    @(posedge pclk) disable iff (!presetn)
      s_single_word |=> literal == $past(instr_r[7:0]);
  endproperty
  a_literal: assert property (p_literal) else $error("literal wrong");
  property p_move;
    @(posedge pclk) disable iff (!presetn)
      (instr_new_r && wait_r == MFD_W_MOVE && prefixed && !ctrl_wr)
      |=> pair_done && move_dest == $past(instr_r[11:0]);
  endproperty
  a_move: assert property (p_move) else $error("move destination wrong");
  property p_target;
    @(posedge pclk) disable iff (!presetn)
      (instr_new_r && wait_r == MFD_W_TARGET && prefixed && !ctrl_wr)
      |=> pair_done && jump_target == {$past(instr_r[11:0]), $past(first_low_r)};
  endproperty
  a_target: assert property (p_target) else $error("jump target wrong");
  // Bus answers in the first access cycle
  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn) (psel && !penable) |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready");
endmodule // mfd_decoder

// ==== rtl/mfd_map.svh ====
// Constants of the instruction field decoder: offsets, fields, resets, timing
`ifndef MFD_MAP_SVH
`define MFD_MAP_SVH
// APB register byte offsets
`define MFD_CTRL_OFF    12'h000
`define MFD_INSTR_OFF   12'h004
`define MFD_ACC_OFF     12'h008
`define MFD_BANK_OFF    12'h00c
`define MFD_FIELDS_OFF  12'h010
`define MFD_ADDR_OFF    12'h014
`define MFD_STATUS_OFF  12'h018
// Instruction field positions
`define MFD_DEST_BIT    9
`define MFD_ACCESS_BIT  8
`define MFD_BITPOS_HI   11
`define MFD_BITPOS_LO   9
`define MFD_PREFIX      4'hf
`define MFD_SUBLIT_OP   8'h08
// Status flag positions
`define MFD_FLAG_C      0
`define MFD_FLAG_DC     1
`define MFD_FLAG_Z      2
`define MFD_FLAG_OV     3
`define MFD_FLAG_N      4
// Reset values
`define MFD_ACC_RST     8'h00
`define MFD_BANK_RST    4'h0
`define MFD_FLAGS_RST   5'h00
// Four Q phases make one instruction cycle
`define MFD_Q_PHASES    4
`endif

// ==== rtl/mfd_pkg.sv ====
// Types shared by the instruction field decoder
package mfd_pkg;
  typedef enum logic [1:0] {
    MFD_Q1 = 2'b00,
    MFD_Q2 = 2'b01,
    MFD_Q3 = 2'b10,
    MFD_Q4 = 2'b11
  } mfd_qphase_e;
  typedef enum logic [1:0] {
    MFD_W_NONE   = 2'b00,
    MFD_W_MOVE   = 2'b01,
    MFD_W_TARGET = 2'b10
  } mfd_wait_e;
endpackage

// ==== rtl/mfd_sub_alu.sv ====
// Literal minus accumulator with status flags
module mfd_sub_alu
  import mfd_pkg::*;
(
  // Operands
  input  wire logic [7:0] lit,
  input  wire logic [7:0] acc,
  // Result
  output logic [7:0]      diff,
  output logic [4:0]      flags
);
`include "mfd_map.svh"
  logic [8:0] full;
  logic [4:0] low;
  always_comb begin
    full = {1'b0, lit} + {1'b0, ~acc} + 9'h001;
    low  = {1'b0, lit[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    diff = full[7:0];
    flags = 5'h00;
    flags[`MFD_FLAG_C]  = full[8];
    flags[`MFD_FLAG_DC] = low[4];
    flags[`MFD_FLAG_Z]  = (full[7:0] == 8'h00);
    flags[`MFD_FLAG_OV] = (lit[7] != acc[7]) && (full[7] != lit[7]);
    flags[`MFD_FLAG_N]  = full[7];
  end
endmodule // mfd_sub_alu

// ==== rtl/mfd_qseq.sv ====
// Four-phase Q sequencer of the core clock
module mfd_qseq
  import mfd_pkg::*;
(
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Phase
  output mfd_qphase_e q
);
  // Free-running Q1..Q4 rotation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= MFD_Q1;
    end else begin
      unique case (q)
        MFD_Q1: q <= MFD_Q2;
        MFD_Q2: q <= MFD_Q3;
        MFD_Q3: q <= MFD_Q4;
        MFD_Q4: q <= MFD_Q1;
      endcase
    end
  end
endmodule // mfd_qseq

// ==== test/mfd_prog_mem.sv ====
// Program memory model that supplies instruction words to the decoder
module mfd_prog_mem (
  // Fetch port
  input  wire logic [3:0]  addr,
  output logic      [15:0] word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] rom [16];

  // Fixed program; spare slots hold a toggling pattern, so a wrong fetch never looks valid
  initial begin
    rom = '{16'h2655, 16'h25aa, 16'h9a3c, 16'h0e7f, 16'hc123, 16'hf456, 16'hef34, 16'hfabc,
            16'h0802, 16'h0802, 16'h08f0, 16'h0880, 16'h5a5a, 16'ha5a5, 16'h5a5a, 16'ha5a5};
  end

  // Combinational read, answers in the same cycle
  assign word = rom[addr];
endmodule // mfd_prog_mem

// ==== test/tb_mcu8_instruction_field_decoder.sv ====
// Self-checking bench of the instruction field decoder over APB
`include "mfd_map.svh"
module tb_mcu8_instruction_field_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, dest_to_file, pair_done;
  logic [11:0] paddr, file_addr, move_dest;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  bank_sel, pm_addr;
  logic [2:0]  bit_pos;
  logic [7:0]  literal, working_accumulator;
  logic [19:0] jump_target;
  logic [4:0]  status_flags;
  logic [15:0] pm_word;
  logic [12:0] e;
  logic        er;
  int          miscompares, n_tests, p;
  int          pd_cnt = 0;
  logic [7:0]  acc_tab [4] = '{8'h01, 8'h03, 8'hf0, 8'h01};

  mfd_decoder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dest_to_file, .bank_sel, .file_addr, .move_dest, .bit_pos, .literal,
    .jump_target, .pair_done, .working_accumulator, .status_flags);
  mfd_prog_mem pm (.addr(pm_addr), .word(pm_word));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Count pair completion pulses; a one-cycle pulse is easy to miss by polling
  always @(posedge pclk) if (pair_done === 1'b1) pd_cnt <= pd_cnt + 1;

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No cycle count is assumed; only the watchdog ends a wait without answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Fetch a word from program memory, issue it, let the fields settle
  task run(input logic [3:0] i);
    pm_addr <= i;
    @(posedge pclk);
    apb(1'b1, `MFD_INSTR_OFF, {16'h0000, pm_word});
    repeat (3) @(posedge pclk);
  endtask

  // Reference difference and flags {N, OV, Z, DC, C}; carry means no borrow
  function automatic logic [12:0] sub_ref(input logic [7:0] l, input logic [7:0] w);
    logic [7:0] d;
    d = l - w;
    return {d, d[7], (l[7] != w[7]) && (d[7] != l[7]), d == 8'h00, l[3:0] >= w[3:0], l >= w};
  endfunction

  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    summarize;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pm_addr = 4'h0;
    miscompares = 0;
    n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MFD_ACC_OFF, 32'h0);
    chk("acc reset", 32'h0, rd);
    apb(1'b0, `MFD_STATUS_OFF, 32'h0);
    chk("flags reset", 32'h0, rd & 32'h1f);
    // Byte ops with both destinations and both bank modes
    run(4'd0);
    chk("dest", 32'h1, dest_to_file);
    chk("bank", 32'h0, bank_sel);
    chk("file", 32'h55, file_addr);
    apb(1'b1, `MFD_BANK_OFF, 32'h5);
    run(4'd1);
    chk("dest", 32'h0, dest_to_file);
    chk("bank", 32'h5, bank_sel);
    chk("file", 32'haa, file_addr);
    run(4'd2);
    chk("bitpos", 32'h5, bit_pos);
    chk("file", 32'h3c, file_addr);
    chk("bank", 32'h0, bank_sel);
    run(4'd3);
    chk("literal", 32'h7f, literal);
    // Two-word move and jump pairing
    run(4'd4);
    apb(1'b1, `MFD_CTRL_OFF, 32'h1);
    p = pd_cnt;
    run(4'd5);
    chk("move dest", 32'h456, move_dest);
    chk("pair pulse", 32'h1, pd_cnt - p);
    apb(1'b0, `MFD_ADDR_OFF, 32'h0);
    chk("addr reg", 32'h00456123, rd);
    run(4'd6);
    apb(1'b1, `MFD_CTRL_OFF, 32'h2);
    p = pd_cnt;
    run(4'd7);
    chk("target", 32'habc34, jump_target);
    chk("pair pulse", 32'h1, pd_cnt - p);
    // A second word without the prefix drops the pairing
    apb(1'b1, `MFD_CTRL_OFF, 32'h1);
    p = pd_cnt;
    run(4'd3);
    chk("no pair pulse", 32'h0, pd_cnt - p);
    chk("move kept", 32'h456, move_dest);
    apb(1'b0, `MFD_CTRL_OFF, 32'h0);
    chk("wait dropped", 32'h0, rd);
    // Unmapped offset is refused
    apb(1'b1, 12'h0fc, 32'hffff_ffff);
    chk("slverr wr", 32'h1, er);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("slverr rd", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    // literal subtract: plain, borrow, zero, overflow
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `MFD_ACC_OFF, {24'h0, acc_tab[i]});
      run(4'(8 + i));
      repeat (12) @(posedge pclk);
      e = sub_ref(pm_word[7:0], acc_tab[i]);
      chk("difference", e[12:5], working_accumulator);
      chk("flags", e[4:0], status_flags);
      apb(1'b0, `MFD_STATUS_OFF, 32'h0);
      chk("status reg", e[4:0], rd & 32'h1f);
    end
    summarize;
  end
endmodule // tb_mcu8_instruction_field_decoder
